// ### hdl/scrc_clock_ctrl.sv
// slow clock source select, system clock source sequencing and rc calibration control
//
// How it works
// [R1] software keeps crystal as system clock for radio
// [R2] forward error correction needs undivided system clock
// [R3] clock divider setting caps radio data rate
// [R4] calibrated rc runs at crystal over 750/1500
// [R5] calibrate only with rc running, crystal stable
// [R6] slow crystal and rc never run together
// [R7] reset enables rc and selects it
// [R8] software changes slow select only on fast rc
// [R9] selecting crystal with rc source starts calibration
// [R10] calibration repeats while on crystal and active
// [R11] one calibration pass takes about 2 ms
// [R12] later calibrations abort on switch or sleep
// [R13] first calibration finishes before request acts
// [R14] later requests act about 130 us after issue
// [R15] software requests only once during first calibration
// [R16] software spaces later requests 130 us apart
// [R17] bit 7 selects slow source, resets 1
// [R18] slow select returns to 1 after deepest modes
// [R19] bit 6 selects system source, resets 1
// [R20] software keeps tick setting not above divider
// [R21] keep source until new fast source stable
// [R22] flag marks first calibration done since selection
`timescale 1ns/1ps
module scrc_clock_ctrl #(
   parameter int unsigned CAL_CYCLES_P = scrc_pkg::CAL_CYCLES,
   parameter bit          XTAL_48M     = 1'b0
) (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   input  wire logic                     ce,
   input  wire scrc_pkg::scrc_apb_req_type apb_req,
   output scrc_pkg::scrc_apb_rsp_type    apb_rsp,
   input  wire logic                     fast_crystal_stable,
   input  wire logic                     fast_rc_stable,
   input  wire logic                     wake_event,
   output logic                          sys_clk_on_crystal,
   output logic                          fast_crystal_en,
   output logic                          fast_rc_en,
   output logic                          slow_crystal_en,
   output logic                          slow_rc_en,
   output logic                          rc_cal_run,
   output logic [10:0]                   rc_cal_divisor,
   output logic [1:0]                    power_mode,
   output logic [2:0]                    system_clock_divider,
   output logic [2:0]                    timer_tick_divider
);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // declarations

   scrc_pkg::scrc_state_type state_r;
   scrc_pkg::scrc_state_type state_nxt;
   logic [7:0]               cc_r;
   logic [7:0]               cc_nxt;
   logic [1:0]               pwr_req_r;
   logic [1:0]               sleep_mode_r;
   logic                     sys_xtal_r;
   logic                     first_done_r;
   logic [31:0]              prdata_r;
   logic                     acc_phase;
   logic                     wr_cc;
   logic                     wr_pwr;
   logic                     pend_deep;
   logic                     pend_switch;
   logic                     pend_any;
   logic                     wake_lost;
   logic                     cal_start;
   logic                     cal_clear;
   logic                     cal_done;
   logic                     cal_busy;
   logic                     abort_start;
   logic                     abort_done;
   logic                     abort_busy;

   // known register addresses, used only by the error decode; read data compares each address itself
   function automatic logic reg_known(input logic [scrc_pkg::ADDR_W-1:0] addr);
      reg_known = (addr == scrc_pkg::CC_ADDR) || (addr == scrc_pkg::PWR_ADDR) || (addr == scrc_pkg::STAT_ADDR);
   endfunction

   // where a deferred or delayed request finally lands
   function automatic scrc_pkg::scrc_state_type act_target(input logic deep);
      act_target = deep ? scrc_pkg::ST_SLEEP : scrc_pkg::ST_GO_RC;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait states while ce is high, the access phase edge commits writes

   assign acc_phase = apb_req.psel && apb_req.penable;
   assign wr_cc     = ce && acc_phase && apb_req.pwrite && (apb_req.paddr == scrc_pkg::CC_ADDR);
   assign wr_pwr    = ce && acc_phase && apb_req.pwrite && (apb_req.paddr == scrc_pkg::PWR_ADDR);

   // read data is captured in the setup cycle so it comes from a flop
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prdata_r <= 32'h00000000;
      end else if (ce && apb_req.psel && !apb_req.penable) begin
         prdata_r <= 32'h00000000;
         if (apb_req.paddr == scrc_pkg::CC_ADDR) begin
            prdata_r[7:0] <= {cc_r[7], ~sys_xtal_r, cc_r[5:0]}; // see [R19]
         end else if (apb_req.paddr == scrc_pkg::PWR_ADDR) begin
            prdata_r[1:0] <= pwr_req_r;
         end else if (apb_req.paddr == scrc_pkg::STAT_ADDR) begin
            prdata_r[scrc_pkg::ST_ON_XTAL]    <= sys_xtal_r;
            prdata_r[scrc_pkg::ST_CAL_RUN]    <= rc_cal_run;
            prdata_r[scrc_pkg::ST_FIRST_DONE] <= first_done_r;
            prdata_r[scrc_pkg::ST_PENDING]    <= pend_any;
            prdata_r[scrc_pkg::ST_ABORTING]   <= (state_r == scrc_pkg::ST_ABORT);
            prdata_r[scrc_pkg::ST_XTAL_STB]   <= fast_crystal_stable;
            prdata_r[scrc_pkg::ST_RC_STB]     <= fast_rc_stable;
         end
      end
   end

   // a frozen block stalls the bus instead of dropping the access
   assign apb_rsp.prdata  = prdata_r;
   assign apb_rsp.pready  = ce;
   assign apb_rsp.pslverr = acc_phase && !reg_known(apb_req.paddr);

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // clock_control register

   assign wake_lost = (state_r == scrc_pkg::ST_SLEEP) && wake_event && (sleep_mode_r >= scrc_pkg::PM_DEEP_LOST);

   // writes are ignored asleep, the cpu is not running then anyway
   always_comb begin
      cc_nxt = cc_r;
      if (wr_cc && state_r != scrc_pkg::ST_SLEEP) begin
         cc_nxt = apb_req.pwdata[7:0];
      end
      if (wake_lost) begin
         cc_nxt[scrc_pkg::CC_SLOW_SEL] = 1'b1; // see [R18]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cc_r <= scrc_pkg::CC_RESET; // see [R7] [R17] [R19]
      end else if (ce) begin
         cc_r <= cc_nxt;
      end
   end

   // deep request register; a new write wins over the clear on entry
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pwr_req_r <= scrc_pkg::PWR_RESET;
      end else if (ce) begin
         if (wr_pwr) begin
            pwr_req_r <= apb_req.pwdata[1:0];
         end else if (state_nxt == scrc_pkg::ST_SLEEP && state_r != scrc_pkg::ST_SLEEP) begin
            pwr_req_r <= scrc_pkg::PM_LIGHT;
         end
      end
   end

   assign pend_deep   = (pwr_req_r != scrc_pkg::PM_LIGHT);
   assign pend_switch = cc_r[scrc_pkg::CC_SYS_SEL];
   assign pend_any    = pend_deep || pend_switch;

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // source sequencing state machine

   always_comb begin
      state_nxt   = state_r;
      cal_start   = 1'b0;
      cal_clear   = 1'b0;
      abort_start = 1'b0;
      case (state_r)
         scrc_pkg::ST_RC: begin
            if (pend_deep) begin
               state_nxt = scrc_pkg::ST_SLEEP;
            end else if (!pend_switch) begin
               state_nxt = scrc_pkg::ST_GO_XTAL;
            end
         end
         scrc_pkg::ST_GO_XTAL: begin
            if (fast_crystal_stable) begin // see [R21]
               if (cc_r[scrc_pkg::CC_SLOW_SEL]) begin
                  state_nxt = scrc_pkg::ST_CAL;
                  cal_start = 1'b1; // see [R9]
               end else begin
                  state_nxt = scrc_pkg::ST_XTAL;
               end
            end
         end
         scrc_pkg::ST_XTAL: begin
            if (pend_any) begin
               state_nxt = act_target(pend_deep);
            end
         end
         scrc_pkg::ST_CAL: begin
            if (!cc_r[scrc_pkg::CC_SLOW_SEL]) begin
               state_nxt = scrc_pkg::ST_XTAL;
               cal_clear = 1'b1;
            end else if (pend_any && first_done_r) begin
               state_nxt   = scrc_pkg::ST_ABORT; // see [R12]
               abort_start = 1'b1;
            end else if (cal_done) begin
               if (pend_any) begin
                  state_nxt = act_target(pend_deep); // see [R13]
               end else begin
                  cal_start = 1'b1; // see [R10]
               end
            end
         end
         scrc_pkg::ST_ABORT: begin
            if (abort_done) begin
               cal_clear = 1'b1; // see [R14]
               state_nxt = act_target(pend_deep);
            end
         end
         scrc_pkg::ST_GO_RC: begin
            if (fast_rc_stable) begin // see [R21]
               state_nxt = scrc_pkg::ST_RC;
            end
         end
         scrc_pkg::ST_SLEEP: begin
            if (wake_event && cc_r[scrc_pkg::CC_SYS_SEL]) begin
               // a crystal kept through sleep hands back through the stability wait
               state_nxt = sys_xtal_r ? scrc_pkg::ST_GO_RC : scrc_pkg::ST_RC; // see [R21]
            end else if (wake_event) begin
               state_nxt = scrc_pkg::ST_GO_XTAL;
            end
         end
         default: begin
            state_nxt = scrc_pkg::ST_RC;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= scrc_pkg::ST_RC;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // actual system source flips only once the new source is stable
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sys_xtal_r <= 1'b0;
      end else if (ce) begin
         if (state_r == scrc_pkg::ST_GO_XTAL && fast_crystal_stable) begin
            sys_xtal_r <= 1'b1; // see [R21]
         end else if (state_r == scrc_pkg::ST_GO_RC && fast_rc_stable) begin
            sys_xtal_r <= 1'b0;
         end
      end
   end

   // first pass flag picks deferral over abort
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         first_done_r <= 1'b0;
      end else if (ce) begin
         if (state_r == scrc_pkg::ST_GO_XTAL) begin
            first_done_r <= 1'b0; // see [R22]
         end else if (state_r == scrc_pkg::ST_CAL && cal_done) begin
            first_done_r <= 1'b1; // see [R22]
         end
      end
   end

   // mode entered is kept for the wake decision
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sleep_mode_r <= scrc_pkg::PM_LIGHT;
      end else if (ce && state_nxt == scrc_pkg::ST_SLEEP && state_r != scrc_pkg::ST_SLEEP) begin
         sleep_mode_r <= pwr_req_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // interval timers; the calibration one only counts while calibration can really run

   scrc_cycle_timer #(.WIDTH(scrc_pkg::TMR_W)) u_cal_timer (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .ce         (ce),
      .start      (cal_start),
      .clear      (cal_clear),
      .run        (rc_cal_run),
      .load_value (scrc_pkg::TMR_W'(CAL_CYCLES_P)), // see [R11]
      .busy       (cal_busy),
      .done       (cal_done)
   );

   scrc_cycle_timer #(.WIDTH(scrc_pkg::TMR_W)) u_abort_timer (
      .ref_clk    (ref_clk),
      .rst        (rst),
      .ce         (ce),
      .start      (abort_start),
      .clear      (1'b0),
      .run        (state_r == scrc_pkg::ST_ABORT),
      .load_value (scrc_pkg::TMR_W'(scrc_pkg::ABORT_CYCLES)), // see [R14]
      .busy       (abort_busy),
      .done       (abort_done)
   );

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // outputs toward the oscillators and clock tree

   assign rc_cal_run = cal_busy && sys_xtal_r && fast_crystal_stable && slow_rc_en
                       && (state_r == scrc_pkg::ST_CAL || state_r == scrc_pkg::ST_ABORT); // see [R5]
   assign rc_cal_divisor       = XTAL_48M ? scrc_pkg::DIV_XTAL_48M : scrc_pkg::DIV_XTAL_26M; // see [R4]
   assign slow_rc_en           = cc_r[scrc_pkg::CC_SLOW_SEL]; // see [R6]
   assign slow_crystal_en      = !cc_r[scrc_pkg::CC_SLOW_SEL]; // see [R6]
   assign sys_clk_on_crystal   = sys_xtal_r;
   assign fast_crystal_en      = sys_xtal_r || !cc_r[scrc_pkg::CC_SYS_SEL];
   assign fast_rc_en           = !sys_xtal_r || cc_r[scrc_pkg::CC_SYS_SEL];
   assign power_mode           = (state_r == scrc_pkg::ST_SLEEP) ? sleep_mode_r : scrc_pkg::PM_LIGHT;
   assign system_clock_divider = cc_r[scrc_pkg::CC_SPD_LSB +: 3];
   assign timer_tick_divider   = cc_r[scrc_pkg::CC_TICK_LSB +: 3];

   ////////////////////////////////////////////////////////////////////////////////////////////////////
   // checks

   logic [scrc_pkg::TMR_W-1:0] cal_age_r;
   logic [scrc_pkg::TMR_W-1:0] abort_age_r;

   // cycles of real calibration and of abort wait since each started
   always_ff @(posedge ref_clk) begin
      if (rst || cal_start) begin
         cal_age_r <= '0;
      end else if (ce && rc_cal_run) begin
         cal_age_r <= cal_age_r + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst || abort_start) begin
         abort_age_r <= '0;
      end else if (ce && state_r == scrc_pkg::ST_ABORT) begin
         abort_age_r <= abort_age_r + 1'b1;
      end
   end

   default clocking chk_cb @(posedge ref_clk); endclocking
   default disable iff (rst || !ce);

   chk_slow_osc_excl: assert property (!(slow_crystal_en && slow_rc_en)) // see [R6]
      else $error("both slow oscillators enabled");
   chk_reset_rc_sel: assert property ($past(rst) |-> slow_rc_en && cc_r[7] && !sys_clk_on_crystal) // see [R7]
      else $error("reset did not select slow rc and fast rc");
   chk_cal_conditions: assert property (rc_cal_run |-> sys_clk_on_crystal && fast_crystal_stable && slow_rc_en) // see [R5]
      else $error("calibration running without crystal or rc");
   chk_cal_on_select: assert property ((state_r == scrc_pkg::ST_GO_XTAL && fast_crystal_stable // see [R9]
      && slow_rc_en) |=> state_r == scrc_pkg::ST_CAL && cal_busy && !first_done_r)
      else $error("crystal selection did not start calibration");
   chk_cal_repeats: assert property ((state_r == scrc_pkg::ST_CAL && cal_done && !pend_any && slow_rc_en) // see [R10]
      |=> state_r == scrc_pkg::ST_CAL && cal_busy && first_done_r)
      else $error("calibration did not repeat");
   chk_cal_length: assert property (cal_done && state_r == scrc_pkg::ST_CAL // see [R11]
      |-> cal_age_r == scrc_pkg::TMR_W'(CAL_CYCLES_P - 1))
      else $error("calibration pass length wrong");
   chk_first_deferred: assert property ((state_r == scrc_pkg::ST_CAL && !first_done_r && pend_any // see [R13]
      && !cal_done) |=> sys_clk_on_crystal && state_r != scrc_pkg::ST_ABORT)
      else $error("request acted during first calibration");
   chk_later_aborts: assert property ((state_r == scrc_pkg::ST_CAL && first_done_r && pend_any // see [R12]
      && slow_rc_en) |=> state_r == scrc_pkg::ST_ABORT ##1 abort_busy)
      else $error("later calibration not aborted");
   chk_abort_delay: assert property (abort_done // see [R14]
      |-> abort_age_r == scrc_pkg::TMR_W'(scrc_pkg::ABORT_CYCLES - 1) && sys_clk_on_crystal)
      else $error("abort delay wrong");
   chk_deep_clears_sel: assert property (wake_lost |=> slow_rc_en) // see [R18]
      else $error("slow select not restored after deep mode");
   chk_switch_waits: assert property ((state_r == scrc_pkg::ST_GO_RC && !fast_rc_stable) // see [R21]
      |=> sys_clk_on_crystal && state_r == scrc_pkg::ST_GO_RC)
      else $error("switched before fast rc stable");

   cov_first_deferred: cover property (state_r == scrc_pkg::ST_CAL && !first_done_r && pend_switch ##1 cal_done);
   cov_abort_path: cover property (state_r == scrc_pkg::ST_ABORT ##1 abort_done);
   cov_repeat_pass: cover property (state_r == scrc_pkg::ST_CAL && cal_done && first_done_r);
   cov_sleep_wake: cover property (wake_lost ##1 state_r == scrc_pkg::ST_GO_XTAL);

endmodule // scrc_clock_ctrl

// ### common/scrc_pkg.sv
// constants, states and bus carriers for the slow clock select and rc calibration block
package scrc_pkg;

   // clock rate and the two timed intervals
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned CAL_TIME_MS    = 2;
   localparam int unsigned CAL_CYCLES     = (CAL_TIME_MS * 1000000) / CLK_PERIOD_NS;
   localparam int unsigned ABORT_TIME_US  = 130;
   localparam int unsigned ABORT_CYCLES   = (ABORT_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int unsigned TMR_W          = 16;

   // register map: printed offset is an index, byte address is four times it
   localparam int unsigned ADDR_W         = 12;
   localparam logic [7:0]  CC_INDEX       = 8'hC6;
   localparam logic [11:0] CC_ADDR        = {2'h0, CC_INDEX, 2'h0};
   localparam logic [11:0] PWR_ADDR       = 12'h31C;
   localparam logic [11:0] STAT_ADDR      = 12'h320;

   // clock_control fields and reset value
   localparam int unsigned CC_SLOW_SEL    = 7;
   localparam int unsigned CC_SYS_SEL     = 6;
   localparam int unsigned CC_TICK_LSB    = 3;
   localparam int unsigned CC_SPD_LSB     = 0;
   localparam logic [7:0]  CC_RESET       = 8'hC9;
   localparam logic [1:0]  PWR_RESET      = 2'h0;

   // power modes and calibration divide ratios
   localparam logic [1:0]  PM_LIGHT       = 2'h0;
   localparam logic [1:0]  PM_DEEP_LOST   = 2'h2;
   localparam logic [10:0] DIV_XTAL_26M   = 11'h2EE;
   localparam logic [10:0] DIV_XTAL_48M   = 11'h5DC;

   // status register bit positions
   localparam int unsigned ST_ON_XTAL     = 0;
   localparam int unsigned ST_CAL_RUN     = 1;
   localparam int unsigned ST_FIRST_DONE  = 2;
   localparam int unsigned ST_PENDING     = 3;
   localparam int unsigned ST_ABORTING    = 4;
   localparam int unsigned ST_XTAL_STB    = 5;
   localparam int unsigned ST_RC_STB      = 6;

   typedef enum logic [6:0] {
      ST_RC      = 7'b0000001,
      ST_GO_XTAL = 7'b0000010,
      ST_XTAL    = 7'b0000100,
      ST_CAL     = 7'b0001000,
      ST_ABORT   = 7'b0010000,
      ST_GO_RC   = 7'b0100000,
      ST_SLEEP   = 7'b1000000
   } scrc_state_type;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } scrc_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } scrc_apb_rsp_type;

endpackage

// ### hdl/scrc_cycle_timer.sv
// loadable down counter that measures calibration and abort intervals
`timescale 1ns/1ps
module scrc_cycle_timer #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             start,
   input  wire logic             clear,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] load_value,
   output logic                  busy,
   output logic                  done
);

   logic [WIDTH-1:0] count_r;

   // clear beats start so an abort never leaves a stale count behind
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_r <= '0;
      end else if (ce) begin
         if (clear) begin
            count_r <= '0;
         end else if (start) begin
            count_r <= load_value;
         end else if (run && count_r != '0) begin
            count_r <= count_r - 1'b1;
         end
      end
   end

   // done pulses in the last counted cycle; it must not look at start, since the owner
   // raises start from done to restart and would otherwise close a combinational loop
   assign busy = (count_r != '0);
   assign done = ce && run && !clear && (count_r == {{(WIDTH-1){1'b0}}, 1'b1});

endmodule // scrc_cycle_timer

// ### test/tb_slow_clock_select_and_rc_calibration.sv
// self-checking bench for the slow clock select and rc calibration block
`timescale 1ns/1ps
module tb_slow_clock_select_and_rc_calibration;
   // short calibration pass keeps the run small; abort interval stays at its real length
   localparam int CAL_P = 20;
   logic                       ref_clk;
   logic                       rst;
   logic                       xtal_stb;
   logic                       frc_stb;
   logic                       wake;
   logic                       ce;
   scrc_pkg::scrc_apb_req_type req;
   scrc_pkg::scrc_apb_rsp_type rsp;
   logic                       on_xtal, xtal_en, frc_en, slow_x_en, slow_rc_en, cal_run;
   logic [10:0]                cal_div;
   logic [1:0]                 pmode;
   logic [2:0]                 spd, tick;
   logic [31:0]                rd;
   logic                       err;
   int                         bad_count, n_tests, n, k;

   scrc_clock_ctrl #(.CAL_CYCLES_P(CAL_P), .XTAL_48M(1'b0)) dut (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .apb_req(req), .apb_rsp(rsp),
      .fast_crystal_stable(xtal_stb), .fast_rc_stable(frc_stb), .wake_event(wake),
      .sys_clk_on_crystal(on_xtal), .fast_crystal_en(xtal_en), .fast_rc_en(frc_en),
      .slow_crystal_en(slow_x_en), .slow_rc_en(slow_rc_en), .rc_cal_run(cal_run),
      .rc_cal_divisor(cal_div), .power_mode(pmode), .system_clock_divider(spd),
      .timer_tick_divider(tick));

   ////////////////////////////////////////////////////////////////////////////////
   // clock at 20 MHz
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // common tasks: compare, verdict, bus cycle, bounded waits
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // setup then access; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int t;
      @(posedge ref_clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= w;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge ref_clk);
      req.penable <= 1'b1;
      t = 0;
      do begin
         @(posedge ref_clk);
         t++;
      end while (rsp.pready !== 1'b1 && t < 50);
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      if (t >= 50) begin
         bad_count++;
         summarize();
      end
   endtask

   // counts edges until the system clock source reaches v
   task automatic wait_xtal(input logic v);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (on_xtal !== v && n < 5000);
      if (n >= 5000) begin
         bad_count++;
         summarize();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      apb(1'b0, scrc_pkg::CC_ADDR, 32'h0);
      chk("clock_control reset", rd, 32'h0000_00C9);
      @(negedge ref_clk);
      chk("slow rc en", slow_rc_en, 1'b1);
      chk("slow crystal en", slow_x_en, 1'b0);
      chk("fast enables after reset", {xtal_en, frc_en}, 2'h1);
      apb(1'b0, 12'h7FC, 32'h0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
   endtask

   // crystal held unstable, then first pass with a deferred switch back
   task automatic t_first_pass();
      xtal_stb <= 1'b0;
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_0089);
      repeat (30) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("held on fast rc", on_xtal, 1'b0);
      @(posedge ref_clk);
      xtal_stb <= 1'b1;
      wait_xtal(1'b1);
      // fast rc held unstable so the switch back must wait for it
      frc_stb <= 1'b0;
      @(negedge ref_clk);
      chk("cal running", cal_run, 1'b1);
      chk("divisor", cal_div, 11'h2EE);
      chk("dividers", {spd, tick}, 6'h09);
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_00C9);
      @(negedge ref_clk);
      chk("deferred switch", on_xtal, 1'b1);
      apb(1'b0, scrc_pkg::STAT_ADDR, 32'h0);
      chk("first pass runs on", rd[scrc_pkg::ST_PENDING -: 3], 3'h5);
      repeat (CAL_P + 4) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("held for stable rc", on_xtal, 1'b1);
      apb(1'b0, scrc_pkg::STAT_ADDR, 32'h0);
      chk("first pass ended", rd[scrc_pkg::ST_PENDING -: 3], 3'h6);
      frc_stb <= 1'b1;
      wait_xtal(1'b0);
      chk("switch after pass", n <= 3, 1'b1);
      $display("test first pass done");
   endtask

   // repeated passes, then a later switch that must go through the abort interval
   task automatic t_abort();
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_0089);
      wait_xtal(1'b1);
      @(negedge ref_clk);
      chk("fast enables on crystal", {xtal_en, frc_en}, 2'h2);
      k = 0;
      repeat (3 * CAL_P) begin
         @(negedge ref_clk);
         if (cal_run === 1'b1) k++;
      end
      chk("cal repeats", k > 2 * CAL_P, 1'b1);
      apb(1'b0, scrc_pkg::STAT_ADDR, 32'h0);
      chk("first done flag", rd[scrc_pkg::ST_FIRST_DONE], 1'b1);
      // radio use with error correction: crystal kept, clock undivided, tick not above it
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_0080);
      @(negedge ref_clk);
      chk("undivided clock", {spd, tick}, 6'h00);
      chk("still on crystal", on_xtal, 1'b1);
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_00C9);
      wait_xtal(1'b0);
      chk("abort delay low", n >= scrc_pkg::ABORT_CYCLES - 2, 1'b1);
      chk("abort delay high", n <= scrc_pkg::ABORT_CYCLES + 10, 1'b1);
      $display("test abort done");
   endtask

   // slow crystal chosen, deep mode entered, select bit comes back as rc
   task automatic t_sleep();
      apb(1'b1, scrc_pkg::CC_ADDR, 32'h0000_0049);
      @(negedge ref_clk);
      chk("slow crystal on", {slow_x_en, slow_rc_en}, 2'h2);
      apb(1'b1, scrc_pkg::PWR_ADDR, 32'h0000_0003);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("deep mode", pmode, 2'h3);
      // a wake seen only while the block is frozen must be lost
      @(posedge ref_clk);
      ce   <= 1'b0;
      wake <= 1'b1;
      @(posedge ref_clk);
      wake <= 1'b0;
      @(posedge ref_clk);
      ce   <= 1'b1;
      @(negedge ref_clk);
      chk("frozen while disabled", pmode, 2'h3);
      @(posedge ref_clk);
      wake <= 1'b1;
      @(posedge ref_clk);
      wake <= 1'b0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      chk("awake", pmode, 2'h0);
      apb(1'b0, scrc_pkg::CC_ADDR, 32'h0);
      chk("select back to rc", rd, 32'h0000_00C9);
      $display("test sleep done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence: reset held 10 cycles, then the scenarios
   initial begin
      rst       = 1'b1;
      req       = '0;
      xtal_stb  = 1'b1;
      frc_stb   = 1'b1;
      wake      = 1'b0;
      ce        = 1'b1;
      bad_count = 0;
      n_tests   = 0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_first_pass();
      t_abort();
      t_sleep();
      summarize();
   end
endmodule // tb_slow_clock_select_and_rc_calibration
